// ### include/bdio_pkg.sv
/*
  Constants, register map and carrier types of the banked digital I/O port.
  Assumes a 100 MHz core clock and a byte-addressed Avalon-MM slave port.
*/
package bdio_pkg;
    localparam int CH_NUM = 8;
    localparam int LINE_NUM = 64;
    localparam int CLK_HZ = 100_000_000;
    // Counter inputs are specified up to this rate; the 3-stage filter needs 2 cycles per level
    localparam int CNT_MAX_RATE_HZ = 10_000_000;
    localparam int CNT_MIN_CYCLES = CLK_HZ / CNT_MAX_RATE_HZ;
    // Pattern memory per bank, in bits, and its 32-bit word count
    localparam int MEM_BITS = 65536;
    localparam int MEM_WORDS = MEM_BITS / 32;
    localparam int MEM_IDX_W = $clog2(MEM_WORDS);

    localparam logic [1:0] WID_8 = 2'h0;
    localparam logic [1:0] WID_16 = 2'h1;
    localparam logic [1:0] WID_32 = 2'h2;

    localparam logic [10:0] OFS_CFG = 11'h000;
    localparam logic [10:0] OFS_DATA = 11'h020;
    localparam logic [10:0] OFS_MEAS = 11'h040;
    localparam logic [10:0] OFS_ID = 11'h060;
    localparam logic [10:0] OFS_MEM_ADDR = 11'h090;
    localparam logic [10:0] OFS_MEM_DATA = 11'h094;
    localparam logic [10:0] OFS_MEM_STEP = 11'h098;
    localparam logic [10:0] OFS_STATUS = 11'h09C;
    localparam logic [10:0] OFS_CNT0 = 11'h0A0;
    localparam logic [10:0] OFS_CNT1 = 11'h0A4;
    localparam logic [10:0] OFS_CLK_DIV = 11'h0A8;
    localparam logic [10:0] OFS_BIT = 11'h100;
    localparam logic [10:0] BLOCK_MASK = 11'h7E0;
    localparam logic [3:0] ID_ENTRIES = 4'hA;

    localparam logic [15:0] ID_BANK1_BASE = 16'h0065;
    localparam logic [15:0] ID_BANK2_BASE = 16'h00C9;
    localparam logic [15:0] ID_CNT0 = 16'h012D;
    localparam logic [15:0] ID_CNT1 = 16'h012E;

    localparam logic [15:0] RST_CLK_DIV = 16'h0000;

    typedef struct packed {
        logic [1:0] width;
        logic inverted_polarity;
        logic open_drain_drive;
        logic dir_out;
    } bdio_cfg_s;

    localparam bdio_cfg_s CFG_RESET = '{width: WID_8, inverted_polarity: 1'b0,
                                        open_drain_drive: 1'b0, dir_out: 1'b0};

    typedef struct packed {
        logic read;
        logic write;
        logic [10:0] address;
        logic [31:0] writedata;
    } bdio_avs_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } bdio_avs_rsp_s;

    typedef struct packed {
        bdio_cfg_s [CH_NUM-1:0] cfg;
        logic [CH_NUM-1:0][7:0] drive;
        logic [LINE_NUM-1:0] pin_out;
        logic [LINE_NUM-1:0] pin_oe;
        logic [LINE_NUM-1:0] sync1;
        logic [LINE_NUM-1:0] sync2;
        logic [LINE_NUM-1:0] sync3;
        logic [LINE_NUM-1:0] line;
        logic ack;
        logic [31:0] rdata;
        logic [MEM_IDX_W:0] mem_addr;
        logic [1:0][MEM_IDX_W-1:0] ptr;
        logic [1:0] irq;
        logic [1:0] cnt_sync1;
        logic [1:0] cnt_sync2;
        logic [1:0] cnt_sync3;
        logic [1:0] cnt_level;
        logic [1:0][31:0] total;
        logic [15:0] clk_div;
        logic [15:0] clk_cnt;
        logic clk_level;
    } bdio_state_s;
endpackage

// ### logic/bdio_port.sv
/*
  Banked 64-line digital I/O port with pattern memories, two totalizers and a clock output.
  Assumes asynchronous pins, external pull-ups for open-drain lines and an Avalon-MM master.
*/
`timescale 1ns/1ps
module bdio_port (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register bus
    input wire bdio_pkg::bdio_avs_req_s avs_req_in,
    output bdio_pkg::bdio_avs_rsp_s avs_rsp_out,
    // Digital lines
    input wire logic [63:0] io_in_in,
    output logic [63:0] io_out_out,
    output logic [63:0] io_oe_out,
    // Handshake pins, three per bank
    input wire logic [5:0] hs_in_in,
    output logic [5:0] hs_out_out,
    output logic [5:0] hs_oe_out,
    // Totalizer inputs and clock output
    input wire logic [1:0] cnt_in_in,
    output logic clk_gen_out,
    // Pattern memory wrap, one per bank
    output logic [1:0] bank_irq_out
);
    bdio_pkg::bdio_state_s r;
    bdio_pkg::bdio_state_s n;
    logic [31:0] mem [2][bdio_pkg::MEM_WORDS];
    logic mem_we;
    logic mem_bank;
    logic [bdio_pkg::MEM_IDX_W-1:0] mem_idx;
    logic [31:0] mem_wdata;

    // Channel whose direction governs channel c
    function automatic logic [2:0] leader(input bdio_pkg::bdio_cfg_s [7:0] cfg, input logic [2:0] c);
        logic [2:0] b0;
        logic [2:0] b2;
        b0 = {c[2], 2'b00};
        b2 = {c[2], 2'b10};
        if (cfg[b0].width == bdio_pkg::WID_32) return b0;
        if (!c[1] && cfg[b0].width == bdio_pkg::WID_16) return b0;
        if (c[1] && cfg[b2].width == bdio_pkg::WID_16) return b2;
        return c;
    endfunction

    function automatic logic [2:0] nbytes(input logic [1:0] w);
        case (w)
            bdio_pkg::WID_16: return 3'h2;
            bdio_pkg::WID_32: return 3'h4;
            default: return 3'h1;
        endcase
    endfunction

    function automatic logic legal_width(input logic [1:0] pos, input logic [1:0] w);
        case (pos)
            2'h0: return w == bdio_pkg::WID_8 || w == bdio_pkg::WID_16 || w == bdio_pkg::WID_32;
            2'h2: return w == bdio_pkg::WID_8 || w == bdio_pkg::WID_16;
            default: return w == bdio_pkg::WID_8;
        endcase
    endfunction

    // Sense value of channel c over its configured width
    function automatic logic [31:0] sense(input bdio_pkg::bdio_state_s s, input logic [2:0] c);
        logic [31:0] v;
        logic [2:0] m;
        logic [2:0] nb;
        v = 32'h0000_0000;
        nb = nbytes(s.cfg[c].width);
        for (int k = 0; k < 4; k++) begin
            m = c + 3'(k);
            if (3'(k) < nb) begin
                if (s.cfg[leader(s.cfg, m)].dir_out) begin
                    v[k*8 +: 8] = s.drive[m];
                end else begin
                    v[k*8 +: 8] = s.line[m*8 +: 8] ^ {8{s.cfg[m].inverted_polarity}};
                end
            end
        end
        return v;
    endfunction

    function automatic logic [31:0] width_mask(input logic [1:0] w);
        case (w)
            bdio_pkg::WID_16: return 32'h0000_FFFF;
            bdio_pkg::WID_32: return 32'hFFFF_FFFF;
            default: return 32'h0000_00FF;
        endcase
    endfunction

    always_comb begin
        logic [10:0] adr;
        logic [10:0] boff;
        logic [10:0] idoff;
        logic [2:0] ch;
        logic [2:0] bch;
        logic [4:0] bidx;
        logic [2:0] lead;
        logic [2:0] m;
        logic [2:0] nb;
        logic [31:0] rd;
        logic [31:0] wd;
        logic [31:0] sv;
        logic [63:0] agree;
        logic [1:0] clvl;
        logic [1:0] irq_set;
        logic [1:0] irq_clr;
        logic [7:0] lv;
        logic bk;
        logic take;
        n = r;
        adr = avs_req_in.address;
        wd = avs_req_in.writedata;
        boff = adr - bdio_pkg::OFS_BIT;
        idoff = adr - bdio_pkg::OFS_ID;
        ch = adr[4:2];
        bch = boff[9:7];
        bidx = boff[6:2];
        lead = 3'h0;
        m = 3'h0;
        nb = 3'h1;
        sv = 32'h0000_0000;
        lv = 8'h00;
        rd = 32'h0000_0000;
        agree = 64'h0000_0000_0000_0000;
        clvl = 2'h0;
        take = 1'b0;
        bk = wd[0];
        irq_set = 2'h0;
        irq_clr = 2'h0;
        mem_we = 1'b0;
        mem_bank = 1'b0;
        mem_idx = '0;
        mem_wdata = 32'h0000_0000;

        // Line input filter: a change counts once stages two and three agree
        n.sync1 = io_in_in;
        n.sync2 = r.sync1;
        n.sync3 = r.sync2;
        agree = ~(r.sync2 ^ r.sync3);
        n.line = (r.sync3 & agree) | (r.line & ~agree);

        // Totalizers count filtered rising edges
        n.cnt_sync1 = cnt_in_in;
        n.cnt_sync2 = r.cnt_sync1;
        n.cnt_sync3 = r.cnt_sync2;
        clvl = (r.cnt_sync3 & ~(r.cnt_sync2 ^ r.cnt_sync3)) | (r.cnt_level & (r.cnt_sync2 ^ r.cnt_sync3));
        n.cnt_level = clvl;
        for (int i = 0; i < 2; i++) begin
            if (clvl[i] && !r.cnt_level[i]) begin
                n.total[i] = r.total[i] + 32'h0000_0001;
            end
        end

        // Clock output: half period of clk_div cycles, stopped while zero
        if (r.clk_div == 16'h0000) begin
            n.clk_cnt = 16'h0000;
            n.clk_level = 1'b0;
        end else if (r.clk_cnt >= r.clk_div - 16'h0001) begin
            n.clk_cnt = 16'h0000;
            n.clk_level = ~r.clk_level;
        end else begin
            n.clk_cnt = r.clk_cnt + 16'h0001;
        end

        // Read value, captured on the first cycle of a read
        if ((adr & bdio_pkg::BLOCK_MASK) == bdio_pkg::OFS_CFG) begin
            // Field order matches the configuration write
            rd = {27'h0000000, r.cfg[ch].dir_out, r.cfg[ch].open_drain_drive,
                  r.cfg[ch].inverted_polarity, r.cfg[ch].width};
        end else if ((adr & bdio_pkg::BLOCK_MASK) == bdio_pkg::OFS_DATA) begin
            rd = sense(r, ch);
        end else if ((adr & bdio_pkg::BLOCK_MASK) == bdio_pkg::OFS_MEAS) begin
            rd = {24'h000000, r.line[ch*8 +: 8]};
        end else if (adr >= bdio_pkg::OFS_ID && idoff[10:2] < 9'(bdio_pkg::ID_ENTRIES)) begin
            case (idoff[5:2])
                4'h8: rd = {16'h0000, bdio_pkg::ID_CNT0};
                4'h9: rd = {16'h0000, bdio_pkg::ID_CNT1};
                default: rd = {16'h0000, (idoff[4] ? bdio_pkg::ID_BANK2_BASE : bdio_pkg::ID_BANK1_BASE)
                                         + {14'h0000, idoff[3:2]}};
            endcase
        end else if (adr == bdio_pkg::OFS_MEM_ADDR) begin
            rd = 32'(r.mem_addr);
        end else if (adr == bdio_pkg::OFS_MEM_DATA) begin
            rd = mem[r.mem_addr[bdio_pkg::MEM_IDX_W]][r.mem_addr[bdio_pkg::MEM_IDX_W-1:0]];
        end else if (adr == bdio_pkg::OFS_MEM_STEP) begin
            rd = {5'h00, r.ptr[1], 5'h00, r.ptr[0]};
        end else if (adr == bdio_pkg::OFS_STATUS) begin
            rd = {30'h00000000, r.irq};
        end else if (adr == bdio_pkg::OFS_CNT0) begin
            rd = r.total[0];
        end else if (adr == bdio_pkg::OFS_CNT1) begin
            rd = r.total[1];
        end else if (adr == bdio_pkg::OFS_CLK_DIV) begin
            rd = {16'h0000, r.clk_div};
        end else if (adr >= bdio_pkg::OFS_BIT && !boff[10]) begin
            sv = sense(r, bch);
            if ({2'h0, bidx} < {nbytes(r.cfg[bch].width), 3'h0}) begin
                rd = {31'h00000000, sv[bidx]};
            end
        end

        // One wait cycle per access; the effect lands on the acknowledging edge
        take = (avs_req_in.read || avs_req_in.write) && r.ack;
        n.ack = (avs_req_in.read || avs_req_in.write) && !r.ack;
        if (avs_req_in.read && !r.ack) begin
            n.rdata = rd;
        end

        if (take && avs_req_in.read && (adr & bdio_pkg::BLOCK_MASK) == bdio_pkg::OFS_MEAS) begin
            n.cfg[ch] = bdio_pkg::CFG_RESET;
        end

        if (take && avs_req_in.write) begin
            if ((adr & bdio_pkg::BLOCK_MASK) == bdio_pkg::OFS_CFG) begin
                n.cfg[ch].inverted_polarity = wd[2];
                n.cfg[ch].open_drain_drive = wd[3];
                n.cfg[ch].dir_out = wd[4];
                if (legal_width(ch[1:0], wd[1:0])) begin
                    n.cfg[ch].width = wd[1:0];
                end
            end else if ((adr & bdio_pkg::BLOCK_MASK) == bdio_pkg::OFS_DATA) begin
                nb = nbytes(r.cfg[ch].width);
                for (int k = 0; k < 4; k++) begin
                    m = ch + 3'(k);
                    if (3'(k) < nb) begin
                        n.drive[m] = wd[k*8 +: 8];
                    end
                end
                n.cfg[leader(r.cfg, ch)].dir_out = 1'b1;
            end else if (adr == bdio_pkg::OFS_MEM_ADDR) begin
                n.mem_addr = wd[bdio_pkg::MEM_IDX_W:0];
            end else if (adr == bdio_pkg::OFS_MEM_DATA) begin
                mem_we = 1'b1;
                mem_bank = r.mem_addr[bdio_pkg::MEM_IDX_W];
                mem_idx = r.mem_addr[bdio_pkg::MEM_IDX_W-1:0];
                mem_wdata = wd;
            end else if (adr == bdio_pkg::OFS_MEM_STEP) begin
                lead = {bk, 2'b00};
                nb = nbytes(r.cfg[lead].width);
                if (r.cfg[lead].dir_out) begin
                    sv = mem[bk][r.ptr[bk]];
                    for (int k = 0; k < 4; k++) begin
                        if (3'(k) < nb) begin
                            n.drive[lead + 3'(k)] = sv[k*8 +: 8];
                        end
                    end
                end else begin
                    mem_we = 1'b1;
                    mem_bank = bk;
                    mem_idx = r.ptr[bk];
                    mem_wdata = sense(r, lead) & width_mask(r.cfg[lead].width);
                end
                n.ptr[bk] = r.ptr[bk] + 1'b1;
                if (&r.ptr[bk]) begin
                    irq_set[bk] = 1'b1;
                end
            end else if (adr == bdio_pkg::OFS_STATUS) begin
                irq_clr = wd[1:0];
            end else if (adr == bdio_pkg::OFS_CNT0) begin
                n.total[0] = 32'h0000_0000;
            end else if (adr == bdio_pkg::OFS_CNT1) begin
                n.total[1] = 32'h0000_0000;
            end else if (adr == bdio_pkg::OFS_CLK_DIV) begin
                n.clk_div = wd[15:0];
            end
        end
        // A wrap in the clearing cycle keeps its flag
        n.irq = (r.irq & ~irq_clr) | irq_set;

        // Pin drive from the registered channel state
        for (int c = 0; c < 8; c++) begin
            lv = r.drive[c] ^ {8{r.cfg[c].inverted_polarity}};
            if (r.cfg[c].open_drain_drive) begin
                n.pin_out[c*8 +: 8] = 8'h00;
                n.pin_oe[c*8 +: 8] = {8{r.cfg[leader(r.cfg, 3'(c))].dir_out}} & ~lv;
            end else begin
                n.pin_out[c*8 +: 8] = lv;
                n.pin_oe[c*8 +: 8] = {8{r.cfg[leader(r.cfg, 3'(c))].dir_out}};
            end
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r <= '0;
            r.cfg <= {8{bdio_pkg::CFG_RESET}};
            r.clk_div <= bdio_pkg::RST_CLK_DIV;
        end else begin
            r <= n;
        end
    end

    // Pattern memories, two per bank pair, no reset
    always_ff @(posedge clk_in) begin
        if (mem_we) begin
            mem[mem_bank][mem_idx] <= mem_wdata;
        end
    end

    assign avs_rsp_out.readdata = r.rdata;
    assign avs_rsp_out.waitrequest = (avs_req_in.read || avs_req_in.write) && !r.ack;
    assign io_out_out = r.pin_out;
    assign io_oe_out = r.pin_oe;
    // Handshake pins are present but idle in this block
    assign hs_out_out = 6'h00;
    assign hs_oe_out = 6'h00;
    assign clk_gen_out = r.clk_level;
    assign bank_irq_out = r.irq;
endmodule

// ### test/bdio_port_checker.sv
/*
  Concurrent checks on the port's bus handshake, reset state and pin behaviour.
  Assumes a master that holds each request until it samples waitrequest low.
*/
`timescale 1ns/1ps
module bdio_port_checker (
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Register bus
    input wire bdio_pkg::bdio_avs_req_s avs_req_in,
    input wire bdio_pkg::bdio_avs_rsp_s avs_rsp_out,
    // Pins
    input wire logic [63:0] io_oe_out,
    input wire logic [5:0] hs_out_out,
    input wire logic [5:0] hs_oe_out,
    input wire logic clk_gen_out,
    input wire logic [1:0] bank_irq_out
);
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    logic req_any;
    logic rd_done;
    assign req_any = avs_req_in.read | avs_req_in.write;
    assign rd_done = avs_req_in.read & ~avs_rsp_out.waitrequest;

    a_wait_first: assert property ($rose(req_any) |-> avs_rsp_out.waitrequest)
        else $error("waitrequest low in the first cycle of a request");
    a_wait_one_cycle: assert property (req_any && avs_rsp_out.waitrequest |=> !avs_rsp_out.waitrequest)
        else $error("waitrequest held longer than one cycle");
    a_idle_no_wait: assert property (!req_any |-> !avs_rsp_out.waitrequest)
        else $error("waitrequest high without a request");
    a_rdata_hold: assert property (!avs_req_in.read |=> $stable(avs_rsp_out.readdata))
        else $error("readdata changed without a read");
    a_unmapped_zero: assert property (rd_done && avs_req_in.address == 11'h7FC |-> avs_rsp_out.readdata == 32'h0)
        else $error("unmapped read returned nonzero data");
    a_reset_inputs: assert property ($fell(rst_in) |-> io_oe_out == 64'h0)
        else $error("line driven right after reset");
    a_reset_quiet: assert property ($fell(rst_in) |-> !clk_gen_out && bank_irq_out == 2'h0)
        else $error("clock or bank flag active right after reset");
    a_hs_hiz: assert property (hs_oe_out == 6'h0 && hs_out_out == 6'h0)
        else $error("handshake pin driven");
    a_meas_input: assert property (rd_done && avs_req_in.address == bdio_pkg::OFS_MEAS
        |-> ##3 io_oe_out[7:0] == 8'h00)
        else $error("measured channel still driven");
    a_meas_bank_two: assert property (rd_done && avs_req_in.address == bdio_pkg::OFS_MEAS + 11'h010
        |-> ##3 io_oe_out[39:32] == 8'h00)
        else $error("measured bank two leader still driven");

    c_read_done: cover property (rd_done);
    c_write_done: cover property (avs_req_in.write && !avs_rsp_out.waitrequest);
    c_meas_leader: cover property (rd_done && avs_req_in.address == bdio_pkg::OFS_MEAS + 11'h010);
    c_bank_wrap: cover property ($rose(bank_irq_out[1]));
endmodule

bind bdio_port bdio_port_checker bdio_port_checker_inst (
    .clk_in(clk_in), .rst_in(rst_in), .avs_req_in(avs_req_in), .avs_rsp_out(avs_rsp_out),
    .io_oe_out(io_oe_out), .hs_out_out(hs_out_out), .hs_oe_out(hs_oe_out),
    .clk_gen_out(clk_gen_out), .bank_irq_out(bank_irq_out));

// ### test/bdio_line_model.sv
/*
  External logic on the 64 lines: resolves each wire from the port's drive and far-side drivers.
  Assumes a pull-up on every line; far-side drivers only act on lines the port releases.
*/
`timescale 1ns/1ps
module bdio_line_model (
    // Port side
    input wire logic [63:0] io_out_in,
    input wire logic [63:0] io_oe_in,
    // Far-side drivers
    input wire logic [63:0] ext_val_in,
    input wire logic [63:0] ext_en_in,
    // Resolved wire
    output logic [63:0] line_out
);
    // Released and undriven lines float to the pull-up level
    assign line_out = (io_oe_in & io_out_in) | (~io_oe_in & ((ext_en_in & ext_val_in) | ~ext_en_in));
endmodule

// ### test/bdio_port_test.sv
/*
  Self-checking bench of the banked digital I/O port: bus reads are checked from a queue of notes.
  Assumes the line model resolves the wires and the checker is bound to the port.
*/
`timescale 1ns/1ps
module bdio_port_test;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    bdio_pkg::bdio_avs_req_s req = '0;
    bdio_pkg::bdio_avs_rsp_s rsp;
    logic [63:0] io_line, io_out, io_oe;
    logic [63:0] ext_val = '0;
    logic [63:0] ext_en = '0;
    logic [1:0] cnt_in = 2'h0;
    logic [31:0] exp_q[$];
    logic [10:0] adr_q[$];
    int num_errors = 0;
    int compares = 0;
    int seed = 32'hd984;
    logic [31:0] d, w;
    logic [7:0] v;
    logic clk_gen;
    logic cg;
    logic [1:0] irq;
    int tog = 0;

    bdio_port bdio_port_inst (.clk_in(clk_in), .rst_in(rst_in), .avs_req_in(req), .avs_rsp_out(rsp),
        .io_in_in(io_line), .io_out_out(io_out), .io_oe_out(io_oe), .hs_in_in(6'h0), .hs_out_out(),
        .hs_oe_out(), .cnt_in_in(cnt_in), .clk_gen_out(clk_gen), .bank_irq_out(irq));
    bdio_line_model bdio_line_model_inst (.io_out_in(io_out), .io_oe_in(io_oe), .ext_val_in(ext_val),
        .ext_en_in(ext_en), .line_out(io_line));

    initial begin
        forever #5 clk_in = ~clk_in;
    end
    initial begin
        repeat (3) @(posedge clk_in);
        rst_in <= 1'b0;
    end

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        compares++;
        if (g !== e) begin
            num_errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic rd_en, input logic [10:0] a, input logic [31:0] dat);
        @(posedge clk_in);
        req <= '{read: rd_en, write: !rd_en, address: a, writedata: dat};
        @(posedge clk_in);
        while (rsp.waitrequest !== 1'b0) begin
            @(posedge clk_in);
        end
        req <= '0;
    endtask
    task automatic wr(input logic [10:0] a, input logic [31:0] dat);
        bus(1'b0, a, dat);
    endtask
    task automatic rd(input logic [10:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        adr_q.push_back(a);
        bus(1'b1, a, 32'h0);
    endtask
    task automatic tally_and_finish;
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // Read data is compared against the oldest note when the read completes
    always @(posedge clk_in) begin
        if (!rst_in && req.read && rsp.waitrequest === 1'b0) begin
            chk($sformatf("readdata at %h", adr_q.pop_front()), exp_q.pop_front(), rsp.readdata);
        end
    end

    initial begin
        #200000;
        num_errors++;
        tally_and_finish();
    end

    initial begin
        @(negedge rst_in);
        for (int i = 0; i < 8; i++) begin
            rd(bdio_pkg::OFS_CFG + 11'(4 * i), 32'h0);
        end
        for (int i = 0; i < 10; i++) begin
            rd(bdio_pkg::OFS_ID + 11'(4 * i), 32'(i < 4 ? 101 + i : (i < 8 ? 197 + i : 293 + i)));
        end
        rd(11'h7FC, 32'h0);
        wr(bdio_pkg::OFS_DATA + 11'h008, 32'h0000FFFB);
        rd(bdio_pkg::OFS_DATA + 11'h008, 32'h000000FB);
        repeat (3) @(posedge clk_in);
        chk("io_out byte2", 64'hFB, io_out[23:16]);
        chk("io_oe byte2", 64'hFF, io_oe[23:16]);
        // 16-bit group with an inverted upper byte; the member's width field is illegal
        wr(bdio_pkg::OFS_CFG, 32'h1);
        rd(bdio_pkg::OFS_CFG, 32'h1);
        wr(bdio_pkg::OFS_CFG + 11'h004, 32'h5);
        rd(bdio_pkg::OFS_CFG + 11'h004, 32'h4);
        d = $random(seed);
        wr(bdio_pkg::OFS_DATA, d);
        rd(bdio_pkg::OFS_DATA, {16'h0, d[15:0]});
        repeat (3) @(posedge clk_in);
        chk("io_out bytes0-1", {48'h0, ~d[15:8], d[7:0]}, io_out[15:0]);
        chk("io_oe bytes0-1", 64'hFFFF, io_oe[15:0]);
        // Memory step follows the first channel's width and direction
        w = $random(seed);
        wr(bdio_pkg::OFS_MEM_ADDR, 32'h0);
        wr(bdio_pkg::OFS_MEM_DATA, w);
        wr(bdio_pkg::OFS_MEM_STEP, 32'h0);
        rd(bdio_pkg::OFS_MEM_STEP, 32'h1);
        rd(bdio_pkg::OFS_DATA, {16'h0, w[15:0]});
        chk("step io_out bytes0-1", {48'h0, ~w[15:8], w[7:0]}, io_out[15:0]);
        chk("step io_out byte2", 64'hFB, io_out[23:16]);
        // Open-drain byte
        wr(bdio_pkg::OFS_CFG + 11'h00C, 32'h8);
        wr(bdio_pkg::OFS_DATA + 11'h00C, 32'h001234A5);
        repeat (3) @(posedge clk_in);
        chk("od io_oe byte3", 64'h5A, io_oe[31:24]);
        chk("od io_out byte3", 64'h0, io_out[31:24]);
        chk("od line byte3", 64'hA5, io_line[31:24]);
        // Inverted input byte driven from the far side
        v = 8'($random(seed));
        wr(bdio_pkg::OFS_CFG + 11'h014, 32'h4);
        ext_en[47:40] <= 8'hFF;
        ext_val[47:40] <= v;
        repeat (6) @(posedge clk_in);
        rd(bdio_pkg::OFS_DATA + 11'h014, {24'h0, ~v});
        rd(11'h38C, {31'h0, ~v[3]});
        rd(11'h39C, {31'h0, ~v[7]});
        rd(11'h3A0, 32'h0);
        ext_en <= '0;
        // 32-bit group on bank two, then a measure on its leader
        w = $random(seed);
        wr(bdio_pkg::OFS_CFG + 11'h010, 32'h2);
        wr(bdio_pkg::OFS_DATA + 11'h010, w);
        repeat (6) @(posedge clk_in);
        chk("io_out bank2", {32'h0, w[31:16], ~w[15:8], w[7:0]}, io_out[63:32]);
        chk("io_oe bank2", 64'hFFFFFFFF, io_oe[63:32]);
        rd(bdio_pkg::OFS_MEAS + 11'h010, {24'h0, w[7:0]});
        rd(bdio_pkg::OFS_CFG + 11'h010, 32'h0);
        chk("io_oe byte4 after measure", 64'h0, io_oe[39:32]);
        // Three filtered pulses on the first totalizer input
        repeat (3) begin
            cnt_in <= 2'h1;
            repeat (4) @(posedge clk_in);
            cnt_in <= 2'h0;
            repeat (4) @(posedge clk_in);
        end
        repeat (4) @(posedge clk_in);
        rd(bdio_pkg::OFS_CNT0, 32'h3);
        rd(bdio_pkg::OFS_CNT1, 32'h0);
        // Clock output with a half period of three cycles, then stopped
        wr(bdio_pkg::OFS_CLK_DIV, 32'h3);
        rd(bdio_pkg::OFS_CLK_DIV, 32'h3);
        cg = clk_gen;
        repeat (60) begin
            @(posedge clk_in);
            if (clk_gen !== cg) tog++;
            cg = clk_gen;
        end
        chk("clk_gen toggles", 64'h14, 64'(tog));
        wr(bdio_pkg::OFS_CLK_DIV, 32'h0);
        repeat (3) @(posedge clk_in);
        chk("clk_gen stopped", 64'h0, clk_gen);
        // Bank two captures a full memory of released lines, wraps and flags
        repeat (bdio_pkg::MEM_WORDS) wr(bdio_pkg::OFS_MEM_STEP, 32'h1);
        rd(bdio_pkg::OFS_STATUS, 32'h2);
        chk("bank_irq", 64'h2, irq);
        rd(bdio_pkg::OFS_MEM_STEP, 32'h1);
        wr(bdio_pkg::OFS_MEM_ADDR, 32'h800);
        rd(bdio_pkg::OFS_MEM_DATA, 32'hFF);
        wr(bdio_pkg::OFS_STATUS, 32'h2);
        rd(bdio_pkg::OFS_STATUS, 32'h0);
        @(posedge clk_in);
        tally_and_finish();
    end
endmodule
